// file: rtl/cir_regs.sv
// Command and interrupt-enable register bank with command tracking
`timescale 1ns/1ns
// How it works
// RULE1: Offset zero reads zero, resets zero
// RULE2: Command register at one, resets 20h
// RULE3: Bit five high turns receiver off
// RULE4: Writing bit four one enters sleep; the code ignores it while the wake-up sequence runs
// RULE5: Clearing sleep wakes; bit reads one meanwhile
// RULE6: Sleep write ignored during software restart
// RULE7: Writing code field starts that command
// RULE8: Code field shows command now running
// RULE9: Enable register at two, resets 80h
// RULE10: Bit seven inverts the interrupt pin
// RULE11: Enables gate each source onto pin
// RULE12: Unknown code returns idle, raises idle flag
// RULE13: Termination raises idle flag, host idle not
// RULE14: Host preserves control bits, writes reserved zero
module cir_regs #(
  parameter logic [15:0] CMD_VALID_MASK    = 16'hFFFF,
  parameter logic [3:0]  SOFT_RESTART_CODE = 4'hF,
  parameter int          WAKE_CYCLES       = cir_pkg::WAKE_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic [cir_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [cir_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [cir_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        cmd_done,
  input  wire logic [cir_pkg::IRQ_SRC_N-1:0] irq_req,
  output logic                             cmd_start,
  output logic      [3:0]                  cmd_running,
  output logic                             receiver_analog_off,
  output logic                             soft_sleep_active,
  output logic                             op_finished_set,
  output logic                             irq_pin
);
  import cir_pkg::*;

  initial begin
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin
      $error("WAKE_CYCLES out of range");
    end
  end

  logic [7:0]  ien_q;
  logic        receiver_analog_off_q;
  logic [3:0]  cmd_q;
  logic        start_q;
  logic        fin_q;
  logic        irq_q;
  logic [7:0]  rdata_q;
  cir_sleep_t  sleep_q;
  cir_sleep_t  sleep_d;
  logic        wake_start;
  logic        wake_busy;
  logic        wr_cmd;
  logic        wr_ien;
  logic [3:0]  new_code;
  logic        code_known;
  logic        restart_active;
  logic        sleep_bit;

  assign wr_cmd         = reg_wr && (reg_addr == OFS_COMMAND);
  assign wr_ien         = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
  assign new_code       = reg_wdata[CMD_MSB:0];
  assign code_known     = CMD_VALID_MASK[new_code];
  assign restart_active = (cmd_q == SOFT_RESTART_CODE) ||
                          (wr_cmd && code_known &&
                           new_code == SOFT_RESTART_CODE);
  assign sleep_bit      = (sleep_q != CIR_AWAKE); // RULE5

  // Enable register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ien_q <= RST_IRQ_ENABLE; // RULE9
    end else if (wr_ien) begin
      ien_q <= reg_wdata; // RULE9
    end
  end

  // Receiver switch-off control
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      receiver_analog_off_q <= RST_COMMAND[BIT_RCV_OFF]; // RULE2
    end else if (wr_cmd) begin
      receiver_analog_off_q <= reg_wdata[BIT_RCV_OFF]; // RULE3
    end
  end

  assign receiver_analog_off = receiver_analog_off_q; // RULE3

  // Command field and idle-flag pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q   <= RST_COMMAND[CMD_MSB:0];
      start_q <= 1'b0;
      fin_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      fin_q   <= 1'b0;
      if (cmd_done && cmd_q != CMD_IDLE) begin
        cmd_q <= CMD_IDLE; // RULE8
        fin_q <= 1'b1; // RULE13
      end
      if (wr_cmd) begin
        if (code_known) begin
          cmd_q   <= new_code; // RULE7
          start_q <= 1'b1; // RULE7
        end else begin
          cmd_q <= CMD_IDLE; // RULE12
          fin_q <= 1'b1; // RULE12
        end
      end
    end
  end

  assign cmd_start       = start_q;
  assign cmd_running     = cmd_q;
  assign op_finished_set = fin_q;

  // Soft power-down sequencing
  always_comb begin
    sleep_d    = sleep_q;
    wake_start = 1'b0;
    case (sleep_q)
      CIR_AWAKE: begin
        if (wr_cmd && reg_wdata[BIT_SOFT_SLEEP] && !restart_active) begin
          sleep_d = CIR_ASLEEP; // RULE4 RULE6
        end
      end
      CIR_ASLEEP: begin
        if (wr_cmd && !reg_wdata[BIT_SOFT_SLEEP]) begin
          sleep_d    = CIR_WAKING; // RULE5
          wake_start = 1'b1;
        end
      end
      CIR_WAKING: begin
        if (!wake_busy && !wake_start) begin
          sleep_d = CIR_AWAKE; // RULE5
        end
      end
      default: begin
        sleep_d = CIR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_q <= CIR_AWAKE;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  assign soft_sleep_active = (sleep_q == CIR_ASLEEP);

  cir_wake_timer #(
    .CYCLES (WAKE_CYCLES)
  ) u_wake (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (wake_start),
    .busy    (wake_busy)
  );

  // Interrupt pin: gated sources, optional inversion
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_q <= RST_IRQ_ENABLE[BIT_IRQ_INVERT];
    end else begin
      irq_q <= (|(irq_req & ien_q[IRQ_SRC_N-1:0])) ^ // RULE11
               ien_q[BIT_IRQ_INVERT]; // RULE10
    end
  end

  assign irq_pin = irq_q;

  // Read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_RESERVED:   rdata_q <= RST_RESERVED; // RULE1
        OFS_COMMAND:    rdata_q <= {2'b00, receiver_analog_off_q, sleep_bit, cmd_q}; // RULE8
        OFS_IRQ_ENABLE: rdata_q <= ien_q;
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // Cycles spent waking, for the checks
  logic [16:0] wake_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_cnt_q <= 17'h0_0000;
    end else if (sleep_q == CIR_WAKING) begin
      wake_cnt_q <= wake_cnt_q + 17'h0_0001;
    end else begin
      wake_cnt_q <= 17'h0_0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence wr_sleep_s;
    wr_cmd && reg_wdata[BIT_SOFT_SLEEP];
  endsequence

  sequence wake_req_s;
    soft_sleep_active && wr_cmd && !reg_wdata[BIT_SOFT_SLEEP];
  endsequence

  rsvd_read_a: assert property ( // RULE1
    reg_rd && reg_addr == OFS_RESERVED |=> reg_rdata == 8'h00)
    else $error("reserved register read nonzero");

  receiver_analog_off_follow_a: assert property ( // RULE3
    wr_cmd |=> receiver_analog_off == $past(reg_wdata[BIT_RCV_OFF]))
    else $error("receiver off bit not taken");

  sleep_enter_a: assert property ( // RULE4
    wr_sleep_s ##0 (sleep_q == CIR_AWAKE && !restart_active)
    |=> soft_sleep_active)
    else $error("sleep not entered");

  sleep_block_a: assert property ( // RULE6
    wr_sleep_s ##0 (sleep_q == CIR_AWAKE && restart_active)
    |=> !soft_sleep_active)
    else $error("sleep entered during restart");

  wake_reads_a: assert property ( // RULE5
    wake_req_s |=> (sleep_bit && !soft_sleep_active))
    else $error("wake-up sequence wrong");

  wake_bound_a: assert property ( // RULE5
    sleep_q == CIR_WAKING |-> wake_cnt_q <= 17'(WAKE_CYCLES))
    else $error("wake-up lasts too long");

  wake_done_a: assert property ( // RULE5
    sleep_q == CIR_WAKING && wake_cnt_q == 17'(WAKE_CYCLES)
    |=> sleep_q == CIR_AWAKE)
    else $error("wake-up did not finish");

  cmd_start_a: assert property ( // RULE7
    wr_cmd && code_known |=> cmd_start && cmd_running == $past(new_code))
    else $error("command not started");

  unknown_idle_a: assert property ( // RULE12
    wr_cmd && !code_known |=> cmd_running == CMD_IDLE && op_finished_set)
    else $error("unknown command not returned to idle");

  host_idle_a: assert property ( // RULE13
    wr_cmd && new_code == CMD_IDLE && code_known &&
    !(cmd_done && cmd_q != CMD_IDLE) |=> !op_finished_set)
    else $error("host idle raised flag");

  cmd_read_a: assert property ( // RULE8
    reg_rd && reg_addr == OFS_COMMAND && !reg_wr && !cmd_done
    |=> reg_rdata[3:0] == cmd_running)
    else $error("command field readback wrong");

  irq_gate_a: assert property ( // RULE11
    (irq_req & ien_q[IRQ_SRC_N-1:0]) == 7'h00 && !wr_ien
    |=> irq_pin == ien_q[BIT_IRQ_INVERT])
    else $error("masked source drove pin");

  irq_inv_a: assert property ( // RULE10
    |(irq_req & ien_q[IRQ_SRC_N-1:0]) && !wr_ien
    |=> irq_pin == !ien_q[BIT_IRQ_INVERT])
    else $error("pin polarity wrong");

endmodule : cir_regs

// file: shared/cir_pkg.sv
// Constants shared by the command and interrupt-enable register bank
package cir_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          IRQ_SRC_N       = 7;
  // Register offsets
  localparam logic [5:0]  OFS_RESERVED    = 6'h00;
  localparam logic [5:0]  OFS_COMMAND     = 6'h01;
  localparam logic [5:0]  OFS_IRQ_ENABLE  = 6'h02;
  // Reset values
  localparam logic [7:0]  RST_RESERVED    = 8'h00;
  localparam logic [7:0]  RST_COMMAND     = 8'h20;
  localparam logic [7:0]  RST_IRQ_ENABLE  = 8'h80;
  // Field positions in command_control
  localparam int          BIT_RCV_OFF     = 5;
  localparam int          BIT_SOFT_SLEEP  = 4;
  localparam int          CMD_MSB         = 3;
  // Field positions in irq_source_enable
  localparam int          BIT_IRQ_INVERT  = 7;
  localparam int          BIT_TX_DONE_EN  = 6;
  localparam int          BIT_RX_DONE_EN  = 5;
  localparam int          BIT_OP_FIN_EN   = 4;
  localparam int          BIT_HI_WARN_EN  = 3;
  localparam int          BIT_LO_WARN_EN  = 2;
  localparam int          BIT_FAULT_EN    = 1;
  localparam int          BIT_COUNTDN_EN  = 0;
  // Command codes
  localparam logic [3:0]  CMD_IDLE        = 4'h0;
  // Wake-up timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          WAKE_TIME_NS    = 1000;
  localparam int          WAKE_CYCLES     =
    (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Soft power-down states
  typedef enum logic [2:0] {
    CIR_AWAKE    = 3'b001,
    CIR_ASLEEP   = 3'b010,
    CIR_WAKING   = 3'b100
  } cir_sleep_t;
endpackage : cir_pkg

// file: rtl/cir_wake_timer.sv
// Wake-up delay counter for leaving soft power-down
`timescale 1ns/1ns
module cir_wake_timer #(
  parameter int CYCLES = cir_pkg::WAKE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  import cir_pkg::*;

  logic [15:0] count_q;

  initial begin
    if (CYCLES < 1 || CYCLES > 65535) begin
      $error("CYCLES out of range");
    end
  end

  // Counts down from CYCLES while busy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
    end else if (start) begin
      count_q <= 16'(CYCLES);
    end else if (count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
    end
  end

  assign busy = (count_q != 16'h0000);

endmodule : cir_wake_timer

// file: sim/cir_engine_model.sv
// Command engine model that ends each started command other than code 0 after a delay
`timescale 1ns/1ns
module cir_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       cmd_start,
  input  wire logic [3:0] cmd_running,
  input  wire logic [3:0] reply_lat,
  output logic            cmd_done
);
  logic [3:0] cnt_q;

  // Done pulse reply_lat cycles after a nonzero command starts, whether or not it still runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q    <= 4'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (cmd_start && cmd_running != 4'h0) begin
        cnt_q <= reply_lat;
      end else if (cnt_q == 4'h1) begin
        cmd_done <= 1'b1;
        cnt_q    <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : cir_engine_model

// file: sim/tb_cir_regs.sv
// Self-checking bench for the command and irq-enable register bank
`timescale 1ns/1ns
module tb_cir_regs;
  import cir_pkg::*;
  localparam int WAKE = 4;
  logic       clk_sys, rst_n, reg_wr, reg_rd, cmd_done, cmd_start;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic [6:0] irq_req;
  logic [3:0] cmd_running, reply_lat;
  logic       receiver_analog_off, soft_sleep_active;
  logic       op_finished_set, irq_pin;
  int         err_count, samples_checked, fin_cnt, f;

  cir_regs #(.CMD_VALID_MASK(16'hFFFD), .WAKE_CYCLES(WAKE)) dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .cmd_done, .irq_req, .cmd_start, .cmd_running,
    .receiver_analog_off, .soft_sleep_active, .op_finished_set,
    .irq_pin);
  cir_engine_model eng (.clk_sys, .rst_n, .cmd_start, .cmd_running,
    .reply_lat, .cmd_done);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (op_finished_set === 1'b1) fin_cnt++;

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [5:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask : rd
  task close_out;
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    close_out;
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    irq_req = 7'h00;
    reply_lat = 4'h1;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("rcv_off", {7'h00, receiver_analog_off}, 8'h01);
    chk("irq_pin", {7'h00, irq_pin}, 8'h01);
    rd(OFS_RESERVED);
    chk("reserved", rd_val, 8'h00);
    rd(OFS_COMMAND);
    chk("command", rd_val, 8'h20);
    rd(OFS_IRQ_ENABLE);
    chk("irq_en", rd_val, 8'h80);
    wr(OFS_RESERVED, 8'hFF);
    rd(OFS_RESERVED);
    chk("reserved_w", rd_val, 8'h00);
    wr(6'h3F, 8'h5A);
    rd(6'h3F);
    chk("unmapped", rd_val, 8'h00);
    wr(OFS_COMMAND, 8'hC0);
    chk("rcv_on", {7'h00, receiver_analog_off}, 8'h00);
    rd(OFS_COMMAND);
    chk("cmd_rsvd", rd_val, 8'h00);
    for (int k = 0; k < 2; k++) begin
      reply_lat = (k == 0) ? 4'h1 : 4'hA;
      f = fin_cnt;
      wr(OFS_COMMAND, 8'h22);
      chk("running", {4'h0, cmd_running}, 8'h02);
      chk("start", {7'h00, cmd_start}, 8'h01);
      rd(OFS_COMMAND);
      chk("cmd_busy", rd_val, 8'h22);
      repeat (14) @(negedge clk_sys);
      chk("fin_end", 8'(fin_cnt - f), 8'h01);
      rd(OFS_COMMAND);
      chk("cmd_idle", rd_val, 8'h20);
    end
    f = fin_cnt;
    wr(OFS_COMMAND, 8'h20);
    repeat (3) @(negedge clk_sys);
    chk("fin_host", 8'(fin_cnt - f), 8'h00);
    f = fin_cnt;
    wr(OFS_COMMAND, 8'h21);
    chk("unk_start", {7'h00, cmd_start}, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("unk_run", {4'h0, cmd_running}, 8'h00);
    chk("unk_fin", 8'(fin_cnt - f), 8'h01);
    wr(OFS_COMMAND, 8'h30);
    chk("sleep_on", {7'h00, soft_sleep_active}, 8'h01);
    rd(OFS_COMMAND);
    chk("sleep_rd", rd_val, 8'h30);
    wr(OFS_COMMAND, 8'h20);
    chk("waking", {7'h00, soft_sleep_active}, 8'h00);
    rd(OFS_COMMAND);
    chk("wake_rd", rd_val, 8'h30);
    repeat (WAKE + 2) @(negedge clk_sys);
    rd(OFS_COMMAND);
    chk("awake_rd", rd_val, 8'h20);
    wr(OFS_COMMAND, 8'h3F);
    chk("rst_sleep", {7'h00, soft_sleep_active}, 8'h00);
    rd(OFS_COMMAND);
    chk("rst_bit4", rd_val & 8'h10, 8'h00);
    repeat (14) @(negedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_IRQ_ENABLE, 8'h01 << i);
      irq_req = 7'h01 << i;
      @(negedge clk_sys);
      chk("irq_on", {7'h00, irq_pin}, 8'h01);
      irq_req = ~(7'h01 << i);
      @(negedge clk_sys);
      chk("irq_off", {7'h00, irq_pin}, 8'h00);
    end
    wr(OFS_IRQ_ENABLE, 8'h81);
    @(negedge clk_sys);
    chk("irq_inv1", {7'h00, irq_pin}, 8'h00);
    irq_req = 7'h00;
    @(negedge clk_sys);
    chk("irq_inv0", {7'h00, irq_pin}, 8'h01);
    rd(OFS_IRQ_ENABLE);
    chk("irq_en_rw", rd_val, 8'h81);
    close_out;
  end
endmodule : tb_cir_regs
